// File: logic/soa_alu.v
// Single-operand ALU datapath with condition codes and low status byte
// Function
// - Arithmetic ops set negative from sign bit, zero when result all zero.
// - Minus-one writes operand-1; overflow on most negative; carry kept.
// - Negate writes two's complement; overflow on most negative; carry unless zero.
// - Flag test keeps operand, sets N,Z from it, clears V and C.
// - Signed right shift keeps sign bit; carry gets old bit 0.
// - Signed left shift fills bit 0 with zero; carry gets old top bit.
// - After shifts and rotates overflow is N xor C.
// - Right rotate: 17-bit ring (9-bit in byte form), bit 0 to carry, carry to top bit.
// - Left rotate: top bit to carry, old carry into bit 0.
// - Byte exchange swaps bytes; N from bit 7, Z from low byte; V,C clear.
// - Carry-add adds carry; V on most positive, C on all ones, with carry.
// - Borrow-subtract subtracts carry; V on most negative; C if zero and carry.
// - Sign fill writes all ones or zeros from N; Z=~N, V clear.
// - Status read copies status byte; N bit 7, Z if zero, V clear.
// - Status read into a register sign-extends bit 7 to the upper byte.
// - Status write replaces status byte but never sets the trace bit.
// - Status write loads the four flags from source bits 0 to 3.
// - Instruction bit 15 selects byte form, else word form.
// - Byte ops on a register touch only the low byte, except byte exchange and status read.
`timescale 1ns/10ps
`include "soa_defines.vh"
module soa_alu (
   input wire i_core_clk,
   input wire i_resetn,
   input wire i_valid,
   input wire [`SOA_OPW-1:0] i_opcode,
   input wire [15:0] i_instr,
   input wire [2:0] i_dst_mode,
   input wire [15:0] i_operand,
   output reg o_result_valid,
   output reg [15:0] o_result,
   output reg o_result_write,
   output reg [7:0] o_proc_status_word,
   output reg o_flag_n,
   output reg o_flag_z,
   output reg o_flag_v,
   output reg o_flag_c
);
   // ==================================================================
   // Processor status low byte; flags live in bits 0 to 3
   reg [7:0] stat_reg;
   reg [7:0] stat_next;
   reg [15:0] res_next;
   reg wr_next;
   reg n_next;
   reg z_next;
   reg v_next;
   reg c_next;

   wire byte_op;
   wire [15:0] opnd;
   wire [15:0] msk;
   wire old_c;
   wire old_n;
   wire op_top;
   wire ev_n;
   wire ev_z;

   // ==================================================================
   // Width handling
   assign byte_op = i_instr[`SOA_INSTR_BYTE_BIT];
   // Byte results other than byte exchange and status read keep the upper byte of the operand, so a register target is untouched above
   assign msk = byte_op ? 16'h00ff : 16'hffff;
   assign opnd = i_operand;
   assign old_c = stat_reg[`SOA_FLAG_C];
   assign old_n = stat_reg[`SOA_FLAG_N];
   assign op_top = byte_op ? opnd[7] : opnd[15];

   // Test for a width-dependent special value
   function is_val;
      input [15:0] v;
      input b;
      input [15:0] wv;
      input [7:0] bv;
      begin
         is_val = b ? (v[7:0] == bv) : (v == wv);
      end
   endfunction

   // Merge a computed value into the active width only
   function [15:0] merge;
      input [15:0] v;
      input [15:0] orig;
      input [15:0] m;
      begin
         merge = (v & m) | (orig & ~m);
      end
   endfunction

   // ==================================================================
   // Flag evaluation of the merged result
   soa_flag_eval u_eval (
      .i_value(res_next),
      .i_byte(byte_op),
      .o_neg(ev_n),
      .o_zero(ev_z)
   );

   // ==================================================================
   // Operation select
   always @* begin
      res_next = opnd;
      wr_next = 1'b1;
      stat_next = stat_reg;
      n_next = 1'b0;
      z_next = 1'b0;
      v_next = 1'b0;
      c_next = old_c;
      case (i_opcode)
         `SOA_OP_MINUS_ONE: begin
            res_next = merge(opnd - 16'h0001, opnd, msk);
            n_next = ev_n;
            z_next = ev_z;
            v_next = is_val(opnd, byte_op, `SOA_W_MOST_NEG, `SOA_B_MOST_NEG);
         end
         `SOA_OP_TWOS_COMP: begin
            res_next = merge(16'h0000 - opnd, opnd, msk);
            n_next = ev_n;
            z_next = ev_z;
            v_next = is_val(res_next, byte_op, `SOA_W_MOST_NEG, `SOA_B_MOST_NEG);
            c_next = ~ev_z;
         end
         `SOA_OP_FLAG_TEST: begin
            wr_next = 1'b0;
            n_next = ev_n;
            z_next = ev_z;
            c_next = 1'b0;
         end
         `SOA_OP_SHR_SIGNED: begin
            if (byte_op)
               res_next = {opnd[15:8], opnd[7], opnd[7:1]};
            else
               res_next = {opnd[15], opnd[15:1]};
            n_next = ev_n;
            z_next = ev_z;
            c_next = opnd[0];
            v_next = ev_n ^ opnd[0];
         end
         `SOA_OP_SHL_SIGNED: begin
            res_next = merge({opnd[14:0], 1'b0}, opnd, msk);
            n_next = ev_n;
            z_next = ev_z;
            c_next = op_top;
            v_next = ev_n ^ op_top;
         end
         `SOA_OP_ROT_RIGHT: begin
            if (byte_op)
               res_next = {opnd[15:8], old_c, opnd[7:1]};
            else
               res_next = {old_c, opnd[15:1]};
            n_next = ev_n;
            z_next = ev_z;
            c_next = opnd[0];
            v_next = ev_n ^ opnd[0];
         end
         `SOA_OP_ROT_LEFT: begin
            res_next = merge({opnd[14:0], old_c}, opnd, msk);
            n_next = ev_n;
            z_next = ev_z;
            c_next = op_top;
            v_next = ev_n ^ op_top;
         end
         `SOA_OP_BYTE_EXCH: begin
            // Always word-sized; the low byte alone decides N and Z
            res_next = {opnd[7:0], opnd[15:8]};
            n_next = opnd[15];
            z_next = (opnd[15:8] == 8'h00);
            c_next = 1'b0;
         end
         `SOA_OP_CARRY_ADD: begin
            res_next = merge(opnd + {15'h0000, old_c}, opnd, msk);
            n_next = ev_n;
            z_next = ev_z;
            v_next = old_c & is_val(opnd, byte_op, `SOA_W_MOST_POS, `SOA_B_MOST_POS);
            c_next = old_c & is_val(opnd, byte_op, `SOA_W_ALL_ONES, `SOA_B_ALL_ONES);
         end
         `SOA_OP_BORROW_SUB: begin
            res_next = merge(opnd - {15'h0000, old_c}, opnd, msk);
            n_next = ev_n;
            z_next = ev_z;
            v_next = is_val(opnd, byte_op, `SOA_W_MOST_NEG, `SOA_B_MOST_NEG);
            c_next = old_c & is_val(opnd, byte_op, 16'h0000, 8'h00);
         end
         `SOA_OP_SIGN_FILL: begin
            res_next = merge({16{old_n}}, opnd, msk);
            n_next = old_n;
            z_next = ~old_n;
         end
         `SOA_OP_STAT_READ: begin
            if (i_dst_mode == `SOA_MODE_REG)
               res_next = {{8{stat_reg[7]}}, stat_reg};
            else
               res_next = {opnd[15:8], stat_reg};
            n_next = stat_reg[7];
            z_next = (stat_reg == 8'h00);
         end
         `SOA_OP_STAT_WRITE: begin
            // Source is only read; trace bit may be cleared but never raised here
            wr_next = 1'b0;
            stat_next = {opnd[7:5], opnd[4] & stat_reg[`SOA_STAT_TRACE_BIT],
               opnd[3:0]};
            n_next = opnd[`SOA_FLAG_N];
            z_next = opnd[`SOA_FLAG_Z];
            v_next = opnd[`SOA_FLAG_V];
            c_next = opnd[`SOA_FLAG_C];
         end
         default: begin
            wr_next = 1'b0;
            n_next = old_n;
            z_next = stat_reg[`SOA_FLAG_Z];
            v_next = stat_reg[`SOA_FLAG_V];
         end
      endcase
      stat_next[`SOA_FLAG_N] = n_next;
      stat_next[`SOA_FLAG_Z] = z_next;
      stat_next[`SOA_FLAG_V] = v_next;
      stat_next[`SOA_FLAG_C] = c_next;
   end

   // ==================================================================
   // Result and status registers, one operation per cycle
   always @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         stat_reg <= 8'h00;
         o_result <= 16'h0000;
         o_result_valid <= 1'b0;
         o_result_write <= 1'b0;
      end else begin
         o_result_valid <= i_valid;
         if (i_valid) begin
            stat_reg <= stat_next;
            o_result <= res_next;
            o_result_write <= wr_next;
         end else begin
            o_result_write <= 1'b0;
         end
      end
   end

   // Outputs mirror the status register directly
   always @* begin
      o_proc_status_word = stat_reg;
      o_flag_n = stat_reg[`SOA_FLAG_N];
      o_flag_z = stat_reg[`SOA_FLAG_Z];
      o_flag_v = stat_reg[`SOA_FLAG_V];
      o_flag_c = stat_reg[`SOA_FLAG_C];
   end
endmodule

// File: logic/soa_defines.vh
// Constants for the single-operand ALU: opcodes, widths, flag positions
`ifndef SOA_DEFINES_VH
`define SOA_DEFINES_VH
// ==================================================================
// Operation codes from the decoder
`define SOA_OPW 4
`define SOA_OP_MINUS_ONE 4'h0
`define SOA_OP_TWOS_COMP 4'h1
`define SOA_OP_FLAG_TEST 4'h2
`define SOA_OP_SHR_SIGNED 4'h3
`define SOA_OP_SHL_SIGNED 4'h4
`define SOA_OP_ROT_RIGHT 4'h5
`define SOA_OP_ROT_LEFT 4'h6
`define SOA_OP_BYTE_EXCH 4'h7
`define SOA_OP_CARRY_ADD 4'h8
`define SOA_OP_BORROW_SUB 4'h9
`define SOA_OP_SIGN_FILL 4'ha
`define SOA_OP_STAT_READ 4'hb
`define SOA_OP_STAT_WRITE 4'hc
// ==================================================================
// Instruction and status layout
`define SOA_INSTR_BYTE_BIT 15
`define SOA_MODE_REG 3'h0
`define SOA_STAT_TRACE_BIT 4
`define SOA_FLAG_C 0
`define SOA_FLAG_V 1
`define SOA_FLAG_Z 2
`define SOA_FLAG_N 3
// ==================================================================
// Special operand values
`define SOA_W_MOST_NEG 16'h8000
`define SOA_W_MOST_POS 16'h7fff
`define SOA_W_ALL_ONES 16'hffff
`define SOA_B_MOST_NEG 8'h80
`define SOA_B_MOST_POS 8'h7f
`define SOA_B_ALL_ONES 8'hff
`endif

// File: logic/soa_flag_eval.v
// Negative and zero evaluation for word or byte results
`timescale 1ns/10ps
module soa_flag_eval (
   input wire [15:0] i_value,
   input wire i_byte,
   output wire o_neg,
   output wire o_zero
);
   // Byte form uses bit 7 as sign and only the low byte for zero
   assign o_neg = i_byte ? i_value[7] : i_value[15];
   assign o_zero = i_byte ? (i_value[7:0] == 8'h00) : (i_value == 16'h0000);
endmodule

// File: verif/soa_alu_properties.sv
// Concurrent checks on the single-operand ALU ports
`timescale 1ns/10ps
`include "soa_defines.vh"
module soa_alu_props (
   input wire i_core_clk,
   input wire i_resetn,
   input wire i_valid,
   input wire [`SOA_OPW-1:0] i_opcode,
   input wire [15:0] i_instr,
   input wire [15:0] i_operand,
   input wire o_result_valid,
   input wire [15:0] o_result,
   input wire o_result_write,
   input wire [7:0] o_proc_status_word,
   input wire o_flag_n,
   input wire o_flag_z,
   input wire o_flag_v,
   input wire o_flag_c
);
   // ====
   // Strobes; word forms only where a figure depends on width
   wire word_op = i_valid && !i_instr[`SOA_INSTR_BYTE_BIT];
   wire dec_w = word_op && (i_opcode == `SOA_OP_MINUS_ONE);
   wire tst_w = word_op && (i_opcode == `SOA_OP_FLAG_TEST);
   wire ror_w = word_op && (i_opcode == `SOA_OP_ROT_RIGHT);
   wire swb = i_valid && (i_opcode == `SOA_OP_BYTE_EXCH);
   wire sh = i_valid && (i_opcode >= `SOA_OP_SHR_SIGNED) && (i_opcode <= `SOA_OP_ROT_LEFT);
   wire status_byte_write = i_valid && (i_opcode == `SOA_OP_STAT_WRITE);
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_resetn);
   // ====
   // Properties
   a_valid_answer: assert property (i_valid |=> o_result_valid)
      else $error("no answer one cycle after an op");
   a_quiet_idle: assert property (!i_valid |=> !o_result_valid && !o_result_write)
      else $error("answer without an op");
   a_dec_value: assert property (dec_w |=> o_result == $past(i_operand) - 16'h0001
      && o_flag_v == ($past(i_operand) == `SOA_W_MOST_NEG)) else $error("minus-one wrong");
   a_dec_carry: assert property (dec_w |=> $stable(o_flag_c))
      else $error("minus-one changed carry");
   a_test_flags: assert property (tst_w |=> !o_flag_v && !o_flag_c && !o_result_write
      && o_flag_z == ($past(i_operand) == 16'h0000)) else $error("test flags wrong");
   a_shift_ovf: assert property (sh |=> o_flag_v == (o_flag_n ^ o_flag_c))
      else $error("shift overflow not n xor c");
   a_ror_ring: assert property (ror_w |=> o_result == {$past(o_flag_c), $past(i_operand[15:1])}
      && o_flag_c == $past(i_operand[0])) else $error("right rotate wrong");
   a_swap_bytes: assert property (swb |=> o_result == {$past(i_operand[7:0]),
      $past(i_operand[15:8])}) else $error("byte exchange wrong");
   a_trace_clear: assert property (!o_proc_status_word[`SOA_STAT_TRACE_BIT])
      else $error("trace bit set");
   a_status_byte_write_flags: assert property (status_byte_write |=> o_proc_status_word[3:0] == $past(i_operand[3:0]))
      else $error("status write flags wrong");
   c_dec: cover property (dec_w);
   c_shift_pair: cover property (sh ##1 sh);
   c_status_byte_write: cover property (status_byte_write);
endmodule
bind soa_alu soa_alu_props u_props (.i_core_clk(i_core_clk), .i_resetn(i_resetn),
   .i_valid(i_valid), .i_opcode(i_opcode), .i_instr(i_instr), .i_operand(i_operand),
   .o_result_valid(o_result_valid), .o_result(o_result), .o_result_write(o_result_write),
   .o_proc_status_word(o_proc_status_word), .o_flag_n(o_flag_n), .o_flag_z(o_flag_z),
   .o_flag_v(o_flag_v), .o_flag_c(o_flag_c));

// File: verif/soa_decoder_model.sv
// Decoder and operand-fetch stand-in that feeds the ALU
`timescale 1ns/10ps
module soa_decoder_model (
   input wire i_clk,
   output reg o_valid,
   output reg [3:0] o_opcode,
   output reg [15:0] o_instr,
   output reg [2:0] o_dst_mode,
   output reg [15:0] o_operand
);
   initial begin
      o_valid = 1'b0;
      o_opcode = 4'h0;
      o_instr = 16'h0000;
      o_dst_mode = 3'h0;
      o_operand = 16'h0000;
   end
   // Request stays up, so back-to-back ops need no idle cycle
   task issue(input [3:0] op, input b, input [2:0] m, input [15:0] d);
      @(negedge i_clk);
      o_valid = 1'b1;
      o_opcode = op;
      o_instr = {b, 15'h0000};
      o_dst_mode = m;
      o_operand = d;
      @(posedge i_clk);
   endtask
   // Releasing the bus inverts opcode and operand; instr and mode keep their old values
   task idle;
      @(negedge i_clk);
      o_valid = 1'b0;
      o_opcode = ~o_opcode;
      o_operand = ~o_operand;
   endtask
endmodule

// File: verif/tb_top.sv
// Self-checking bench for the single-operand ALU
`timescale 1ns/10ps
`include "soa_defines.vh"
module tb_top;
   typedef struct packed {
      logic [7:0] st;
      logic [3:0] op;
      logic [3:0] bm;
      logic [15:0] opnd;
      logic [15:0] res;
      logic [3:0] fl;
   } soa_row_t;
   reg clk = 1'b0;
   reg rst_n = 1'b0;
   wire vld, rv, rw, n, z, v, c;
   wire [3:0] opc;
   wire [15:0] ins, opd, res;
   wire [2:0] mode;
   wire [7:0] psw;
   wire [3:0] fl = {n, z, v, c};
   soa_row_t r [0:15];
   int n_fail = 0;
   int checks_done = 0;
   int i;
   task chk(input [15:0] seen, input [15:0] exp, input string nm);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task give_verdict;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      forever #5 clk = ~clk;
   end
   // Whole run is about 64 cycles
   initial begin
      #20000;
      n_fail++;
      give_verdict;
   end
   soa_decoder_model dec (.i_clk(clk), .o_valid(vld), .o_opcode(opc), .o_instr(ins),
      .o_dst_mode(mode), .o_operand(opd));
   soa_alu uut (.i_core_clk(clk), .i_resetn(rst_n), .i_valid(vld), .i_opcode(opc),
      .i_instr(ins), .i_dst_mode(mode), .i_operand(opd), .o_result_valid(rv), .o_result(res),
      .o_result_write(rw), .o_proc_status_word(psw), .o_flag_n(n), .o_flag_z(z),
      .o_flag_v(v), .o_flag_c(c));
   initial begin
      // ====
      // Rows: status preset, op, {byte, mode}, operand, result, nzvc
      r[0] = {8'h01, `SOA_OP_MINUS_ONE, 4'h0, 16'h8000, 16'h7fff, 4'h3};
      r[1] = {8'h00, `SOA_OP_MINUS_ONE, 4'h8, 16'h1280, 16'h127f, 4'h2};
      r[2] = {8'h00, `SOA_OP_TWOS_COMP, 4'h0, 16'h0008, 16'hfff8, 4'h9};
      r[3] = {8'h00, `SOA_OP_TWOS_COMP, 4'h0, 16'h8000, 16'h8000, 4'hb};
      r[4] = {8'h00, `SOA_OP_SHR_SIGNED, 4'h0, 16'h8001, 16'hc000, 4'h9};
      r[5] = {8'h00, `SOA_OP_SHL_SIGNED, 4'h8, 16'h00c0, 16'h0080, 4'h9};
      r[6] = {8'h01, `SOA_OP_ROT_RIGHT, 4'h0, 16'h0002, 16'h8001, 4'ha};
      r[7] = {8'h01, `SOA_OP_ROT_LEFT, 4'h8, 16'h0080, 16'h0001, 4'h3};
      r[8] = {8'h0f, `SOA_OP_BYTE_EXCH, 4'h0, 16'h8001, 16'h0180, 4'h8};
      r[9] = {8'h01, `SOA_OP_CARRY_ADD, 4'h0, 16'h7fff, 16'h8000, 4'ha};
      r[10] = {8'h01, `SOA_OP_CARRY_ADD, 4'h8, 16'h00ff, 16'h0000, 4'h5};
      r[11] = {8'h00, `SOA_OP_BORROW_SUB, 4'h8, 16'h0080, 16'h0080, 4'ha};
      r[12] = {8'h09, `SOA_OP_SIGN_FILL, 4'h0, 16'h1234, 16'hffff, 4'h9};
      r[13] = {8'h06, `SOA_OP_SIGN_FILL, 4'h0, 16'h1234, 16'h0000, 4'h4};
      r[14] = {8'h83, `SOA_OP_STAT_READ, 4'h8, 16'h0000, 16'hff83, 4'h9};
      r[15] = {8'h05, `SOA_OP_STAT_READ, 4'h9, 16'hab00, 16'hab05, 4'h1};
      repeat (8) @(negedge clk);
      chk({8'h00, psw}, 16'h0000, "reset status");
      rst_n = 1'b1;
      for (i = 0; i < 16; i++) begin
         dec.issue(`SOA_OP_STAT_WRITE, 1'b1, 3'h0, {8'h00, r[i].st});
         dec.issue(r[i].op, r[i].bm[3], r[i].bm[2:0], r[i].opnd);
         dec.idle();
         #1;
         chk(res, r[i].res, "result");
         chk({12'h000, fl}, {12'h000, r[i].fl}, "flags");
         chk({15'h0000, rv}, 16'h0001, "valid");
         chk({15'h0000, rw}, 16'h0001, "write");
      end
      // ====
      // Back to back: carry from the op just before, trace bit refused
      dec.issue(`SOA_OP_STAT_WRITE, 1'b1, 3'h0, 16'h00fe);
      #1;
      chk({8'h00, psw}, 16'h00ee, "status byte");
      chk({15'h0000, rw}, 16'h0000, "write back");
      dec.issue(`SOA_OP_ROT_LEFT, 1'b0, 3'h0, 16'h8000);
      #1;
      chk(res, 16'h0000, "rotate result");
      chk({12'h000, fl}, 16'h0007, "rotate flags");
      dec.issue(`SOA_OP_ROT_LEFT, 1'b0, 3'h0, 16'h0000);
      #1;
      chk(res, 16'h0001, "chained carry");
      dec.issue(`SOA_OP_FLAG_TEST, 1'b0, 3'h0, 16'h8000);
      dec.idle();
      #1;
      chk(res, 16'h8000, "test operand");
      chk({12'h000, fl}, 16'h0008, "test flags");
      chk({15'h0000, rw}, 16'h0000, "test write");
      dec.idle();
      #1;
      chk({15'h0000, rv}, 16'h0000, "valid pulse");
      @(negedge clk);
      rst_n = 1'b0;
      #1;
      chk(res, 16'h0000, "mid reset result");
      chk({8'h00, psw}, 16'h0000, "mid reset status");
      @(negedge clk);
      rst_n = 1'b1;
      give_verdict;
   end
endmodule
